// ---- hw/pcs_core.sv ----
// Program counter, latch, pointer and data routing of the core
`timescale 1ns/1ns
`include "pcs_defines.svh"
module pcs_core (
    input  wire logic            mclk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire pcs_pkg::pcs_op_e op,
    input  wire logic [10:0]     jump_field,
    input  wire logic [6:0]      file_addr,
    input  wire logic            file_wr,
    input  wire logic            file_rd,
    input  wire logic [7:0]      file_wdata,
    input  wire logic [7:0]      ram_rdata,
    output logic      [7:0]      file_rdata,
    output logic      [12:0]     program_counter,
    output logic      [8:0]      ram_addr,
    output logic                 ram_wr,
    output logic      [7:0]      ram_wdata,
    output logic      [7:0]      status_out
);
    import pcs_pkg::*;

    // State of the block apart from the return stack, which pcs_stack holds
    typedef struct packed {
        logic [12:0] pc;
        logic [4:0]  lath;
        logic [7:0]  fptr;
        logic [7:0]  stat;
        logic [7:0]  rdata;
        logic [8:0]  raddr;
        logic        rwr;
        logic [7:0]  rwdata;
        logic        rd_q;
    } pcs_core_s;

    pcs_core_s st_ff;   // Registered state
    pcs_core_s nxt_st;  // Next state

    logic [12:0] stk_top;    // Newest return address
    logic [8:0]  eff_addr;   // Resolved data address
    logic        self_ref;   // Pointer aimed at port
    logic        push;       // Stack push this cycle
    logic        pop;        // Stack pop this cycle
    logic        pcl_wr;     // Low byte written
    logic        reg_hit;    // Access hits a local register

    // Subroutine jump and interrupt both push (see R9)
    assign push = (op == PCS_OP_CALL) || (op == PCS_OP_INT);
    // Only the single return operation pops (see R10)
    assign pop  = (op == PCS_OP_RET);

    pcs_stack u_stack (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .push     (push),
        .pop      (pop),
        .push_val (st_ff.pc),
        .top_val  (stk_top)
    );

    pcs_indirect u_ind (
        .file_addr    (file_addr),
        .file_pointer (st_ff.fptr),
        .status       (st_ff.stat),
        .eff_addr     (eff_addr),
        .self_ref     (self_ref)
    );

    // Next state: counter, local registers, data path
    always_comb begin
        nxt_st = st_ff;
        pcl_wr = 1'b0;
        reg_hit = 1'b0;
        nxt_st.rwr = 1'b0;
        nxt_st.rd_q = 1'b0;
        // Only the low seven bits name local registers
        if (self_ref) begin
            reg_hit = 1'b0;
        end else if (eff_addr[6:0] == `PCS_A_PCL ||
                     eff_addr[6:0] == `PCS_A_STATUS ||
                     eff_addr[6:0] == `PCS_A_FSR ||
                     eff_addr[6:0] == `PCS_A_COUNTER_HIGH_LATCH) begin
            reg_hit = 1'b1;
        end
        // Counter update per flow operation
        case (op)
            PCS_OP_STEP: begin
                nxt_st.pc = st_ff.pc + 13'h0001;  // see R20
            end
            PCS_OP_JUMP,
            PCS_OP_CALL: begin
                // Latch bits 4:3 over eleven field bits (see R5, R21)
                nxt_st.pc = {st_ff.lath[4:3], jump_field};
            end
            PCS_OP_RET: begin
                nxt_st.pc = stk_top;  // Latch kept (see R11)
            end
            PCS_OP_INT: begin
                nxt_st.pc = `PCS_INT_VEC;  // see R17
            end
            default: begin
                nxt_st.pc = st_ff.pc;
            end
        endcase
        // Writes; self-pointing indirect writes are dropped (see R15)
        if (file_wr && !self_ref) begin
            if (reg_hit) begin
                if (eff_addr[6:0] == `PCS_A_PCL) begin
                    // Whole upper part from latch, no carry (see R4, R6)
                    pcl_wr = 1'b1;
                    nxt_st.pc = {st_ff.lath, file_wdata};
                end else if (eff_addr[6:0] == `PCS_A_STATUS) begin
                    nxt_st.stat = file_wdata;
                end else if (eff_addr[6:0] == `PCS_A_FSR) begin
                    nxt_st.fptr = file_wdata;
                end else begin
                    nxt_st.lath = file_wdata[4:0];
                end
            end else begin
                nxt_st.rwr = 1'b1;
                nxt_st.raddr = eff_addr;
                nxt_st.rwdata = file_wdata;
            end
        end
        // Reads; upper counter bits never visible (see R1, R2)
        if (file_rd) begin
            nxt_st.raddr = eff_addr;
            nxt_st.rd_q = !reg_hit && !self_ref;
            if (self_ref) begin
                nxt_st.rdata = 8'h00;  // see R15
            end else if (eff_addr[6:0] == `PCS_A_PCL) begin
                nxt_st.rdata = st_ff.pc[7:0];
            end else if (eff_addr[6:0] == `PCS_A_STATUS) begin
                nxt_st.rdata = st_ff.stat;
            end else if (eff_addr[6:0] == `PCS_A_FSR) begin
                nxt_st.rdata = st_ff.fptr;
            end else if (eff_addr[6:0] == `PCS_A_COUNTER_HIGH_LATCH) begin
                nxt_st.rdata = {3'h0, st_ff.lath};
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
    end

    // State register; reset clears the counter to the entry (see R3, R17)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.pc <= `PCS_RESET_VEC;
            st_ff.lath <= `PCS_LATH_RST;
            st_ff.fptr <= `PCS_FSR_RST;
            st_ff.stat <= `PCS_STAT_RST;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // Memory reads pass external data straight through one cycle later
    assign file_rdata      = st_ff.rd_q ? ram_rdata : st_ff.rdata;
    assign program_counter = st_ff.pc;
    assign ram_addr        = st_ff.raddr;
    assign ram_wr          = st_ff.rwr;
    assign ram_wdata       = st_ff.rwdata;
    assign status_out      = st_ff.stat;

    // Low byte write: upper bits equal latch one cycle later
    pcl_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && pcl_wr |=> program_counter[12:8] == $past(st_ff.lath)) // see R4
        else $error("upper counter bits not loaded from latch");

    jump_top_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && op == PCS_OP_JUMP && !file_wr
        |=> program_counter == {$past(st_ff.lath[4:3]), $past(jump_field)})
        else $error("jump target wrong"); // see R5

    step_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && op == PCS_OP_STEP && !file_wr
        |=> program_counter == $past(program_counter) + 13'h0001) // see R20
        else $error("counter did not step by one");

    int_vec_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && op == PCS_OP_INT && !file_wr
        |=> program_counter == `PCS_INT_VEC) // see R17
        else $error("interrupt entry not taken");

    // Call then return restores the counter value held at the call
    sequence call_ret_s;
        ce && op == PCS_OP_CALL && !file_wr ##1
        ce && op == PCS_OP_RET && !file_wr;
    endsequence
    call_ret_a: assert property (@(posedge mclk) disable iff (!rst_n)
        call_ret_s |=> program_counter == $past(program_counter, 2)) // see R10
        else $error("return did not restore pushed counter");

    latch_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && (push || pop) && !file_wr |=> st_ff.lath == $past(st_ff.lath))
        else $error("latch changed by stack action"); // see R11

    self_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && file_rd && self_ref |=> file_rdata == 8'h00) // see R15
        else $error("self-pointing read not zero");

    ind_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && file_wr && file_addr == `PCS_IND_ADDR && !self_ref
        && !reg_hit |=> ram_wr && ram_addr == {$past(st_ff.stat[7]),
        $past(st_ff.fptr)}) // see R16
        else $error("indirect address wrong");
endmodule

// ---- hw/pcs_defines.svh ----
// Constants of the program counter, return stack and indirect access block
// Behaviour
// R1: Thirteen bit counter, low byte read/write
// R2: Upper counter bits only from high latch
// R3: Any reset clears the counter
// R4: Low byte write loads upper from latch
// R5: Jumps take top two bits from latch
// R6: Software bumps latch on table wrap
// R7: Eight entry thirteen bit return stack
// R8: Stack pointer hidden from software
// R9: Push on subroutine jump and interrupt
// R10: Pop on return, literal and interrupt exits
// R11: Push and pop leave latch unchanged
// R12: Stack wraps circularly, oldest overwritten
// R13: No overflow or underflow flag
// R14: Indirect port reaches pointed location
// R15: Self-pointing read zero, write dropped
// R16: Bank bit above pointer forms address
// R17: Reset entry zero, interrupt entry four
// R18: Software keeps indirect bank bit clear
// R19: Status bit five selects direct bank
// R20: Counter steps by one per fetch
// R21: Jump low eleven bits from instruction
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH
`define PCS_PC_W        13
`define PCS_RESET_VEC   13'h0000
`define PCS_INT_VEC     13'h0004
`define PCS_STK_DEPTH   8
`define PCS_STK_PTR_W   3
`define PCS_JMP_FIELD_W 11
`define PCS_IND_ADDR    7'h00
`define PCS_LATH_RST    5'h00
`define PCS_STAT_RST    8'h18
`define PCS_FSR_RST     8'h00
`define PCS_IRP_BIT     7
`define PCS_RP0_BIT     5
`define PCS_A_PCL       7'h02
`define PCS_A_STATUS    7'h03
`define PCS_A_FSR       7'h04
`define PCS_A_COUNTER_HIGH_LATCH    7'h0A
`endif

// ---- hw/pcs_pkg.sv ----
// Types shared by the program counter block
package pcs_pkg;
    // Flow operation delivered by the decoder each instruction cycle
    typedef enum logic [2:0] {
        PCS_OP_NONE,
        PCS_OP_STEP,
        PCS_OP_JUMP,
        PCS_OP_CALL,
        PCS_OP_RET,
        PCS_OP_INT
    } pcs_op_e;
endpackage

// ---- hw/pcs_stack.sv ----
// Eight entry circular return stack
`timescale 1ns/1ns
`include "pcs_defines.svh"
module pcs_stack (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        push,
    input  wire logic        pop,
    input  wire logic [12:0] push_val,
    output logic      [12:0] top_val
);
    import pcs_pkg::*;

    // Pointer and storage held together; eight slots of thirteen bits,
    // outside program and data space (see R7)
    typedef struct packed {
        logic [`PCS_STK_PTR_W-1:0]                    ptr;
        logic [`PCS_STK_DEPTH-1:0][`PCS_PC_W-1:0]     mem;
    } pcs_stk_s;

    pcs_stk_s stk_ff;   // Registered state
    pcs_stk_s nxt_stk;  // Next state

    // Popped value is the newest entry, below the pointer
    assign top_val = stk_ff.mem[stk_ff.ptr - 3'h1];

    // Pointer wraps naturally, no overflow flag exists (see R12, R13)
    always_comb begin
        nxt_stk = stk_ff;
        if (push) begin
            nxt_stk.mem[stk_ff.ptr] = push_val;
            nxt_stk.ptr = stk_ff.ptr + 3'h1;
        end else if (pop) begin
            nxt_stk.ptr = stk_ff.ptr - 3'h1;
        end
    end

    // Pointer has no software path at all (see R8)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stk_ff <= '0;
        end else if (ce) begin
            stk_ff <= nxt_stk;
        end
    end

    // Ninth push lands where the first one did
    wrap_ptr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ce && push |=> stk_ff.ptr == $past(stk_ff.ptr) + 3'h1) // see R12
        else $error("stack pointer did not advance on push");
endmodule

// ---- hw/pcs_indirect.sv ----
// Indirect address former and bank selection
`timescale 1ns/1ns
`include "pcs_defines.svh"
module pcs_indirect (
    input  wire logic [6:0] file_addr,
    input  wire logic [7:0] file_pointer,
    input  wire logic [7:0] status,
    output logic      [8:0] eff_addr,
    output logic            self_ref
);
    import pcs_pkg::*;
    logic is_ind;  // Instruction names the indirect port

    // Port has no storage; pointer picks the real location (see R14)
    always_comb begin
        is_ind = (file_addr == `PCS_IND_ADDR);
        if (is_ind) begin
            // Bank bit above the pointer (see R16)
            eff_addr = {status[`PCS_IRP_BIT], file_pointer};
        end else begin
            // Direct bank from status bit five (see R19)
            eff_addr = {1'b0, status[`PCS_RP0_BIT], file_addr};
        end
        // Pointer aimed at the port itself (see R15)
        self_ref = is_ind && (file_pointer[6:0] == `PCS_IND_ADDR);
    end
endmodule

// ---- sim/pcs_ram_model.sv ----
// Data memory model on the far side of the block's memory port
`timescale 1ns/1ns
module pcs_ram_model (
    input  wire logic       mclk,
    input  wire logic [8:0] ram_addr,
    input  wire logic       ram_wr,
    input  wire logic [7:0] ram_wdata,
    output logic      [7:0] ram_rdata
);
    logic [7:0] mem [0:511]; // Whole nine bit space

    // Read follows the registered address with no delay
    assign ram_rdata = mem[ram_addr];

    // Write lands on the edge that ends the pulse
    always @(posedge mclk) begin
        if (ram_wr === 1'b1) begin
            mem[ram_addr] <= ram_wdata;
        end
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the program counter block
`timescale 1ns/1ns
module tb;
    import pcs_pkg::*;
    logic        mclk, rst_n, ce, file_wr, file_rd, ram_wr;
    pcs_op_e     op;
    logic [10:0] jump_field;
    logic [6:0]  file_addr;
    logic [7:0]  file_wdata, ram_rdata, file_rdata, ram_wdata, status_out;
    logic [12:0] program_counter, exp_pc;
    logic [12:0] stk [8];   // Reference copy of the return stack
    logic [8:0]  ram_addr;
    int          num_errors, samples_checked, sp;

    pcs_core dut_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .op(op),
        .jump_field(jump_field), .file_addr(file_addr),
        .file_wr(file_wr), .file_rd(file_rd), .file_wdata(file_wdata),
        .ram_rdata(ram_rdata), .file_rdata(file_rdata),
        .program_counter(program_counter), .ram_addr(ram_addr),
        .ram_wr(ram_wr), .ram_wdata(ram_wdata), .status_out(status_out));
    pcs_ram_model ram_u (.mclk(mclk), .ram_addr(ram_addr),
        .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

    // Free running clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // One instruction cycle; values seen on return are pre-edge
    task automatic cyc(input pcs_op_e o, input logic [10:0] j,
        input logic [6:0] a, input logic w, input logic r,
        input logic [7:0] d);
        op <= o;
        jump_field <= j;
        file_addr <= a;
        file_wr <= w;
        file_rd <= r;
        file_wdata <= d;
        @(posedge mclk);
    endtask
    task automatic wf(input logic [6:0] a, input logic [7:0] d);
        cyc(PCS_OP_NONE, 11'h000, a, 1'b1, 1'b0, d);
    endtask
    task automatic rf(input logic [6:0] a);
        cyc(PCS_OP_NONE, 11'h000, a, 1'b0, 1'b1, 8'h00);
    endtask
    task automatic idle();
        cyc(PCS_OP_NONE, 11'h000, 7'h00, 1'b0, 1'b0, 8'h00);
    endtask
    task automatic chk(input string n, input logic [12:0] e,
        input logic [12:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    // Low byte write, jump field, stepping and clock enable
    task automatic t_flow();
        wf(7'h0A, 8'h15);
        wf(7'h02, 8'h3C);
        rf(7'h02);
        chk("pc", 13'h153C, program_counter);
        idle();
        chk("low", 13'h003C, {5'h00, file_rdata});
        cyc(PCS_OP_JUMP, 11'h7FF, 7'h00, 1'b0, 1'b0, 8'h00);
        cyc(PCS_OP_STEP, 11'h000, 7'h00, 1'b0, 1'b0, 8'h00);
        chk("pc", 13'h17FF, program_counter);
        idle();
        chk("pc", 13'h1800, program_counter);
        ce <= 1'b0;
        cyc(PCS_OP_STEP, 11'h000, 7'h00, 1'b0, 1'b0, 8'h00);
        ce <= 1'b1;
        idle();
        chk("pc", 13'h1800, program_counter);
    endtask

    // Nine pushes, one of them an interrupt, then nine pops
    task automatic t_stack();
        exp_pc = 13'h1800;
        sp = 0;
        for (int i = 0; i < 9; i++) begin
            cyc((i == 4) ? PCS_OP_INT : PCS_OP_CALL, 11'h100 + 11'(i),
                7'h00, 1'b0, 1'b0, 8'h00);
            stk[sp] = exp_pc;
            sp = (sp + 1) % 8;
            exp_pc = (i == 4) ? 13'h0004 : {2'b10, 11'h100 + 11'(i)};
            idle();
            chk("push", exp_pc, program_counter);
        end
        for (int i = 0; i < 9; i++) begin
            cyc(PCS_OP_RET, 11'h000, 7'h00, 1'b0, 1'b0, 8'h00);
            sp = (sp + 7) % 8;
            exp_pc = stk[sp];
            idle();
            chk("pop", exp_pc, program_counter);
        end
        rf(7'h0A);
        idle();
        chk("latch", 13'h0015, {5'h00, file_rdata});
    endtask

    // Indirect and direct addressing, self pointing port
    task automatic t_data();
        wf(7'h04, 8'h45);
        wf(7'h03, 8'h98); // Bank bit set on purpose
        wf(7'h00, 8'h5A);
        idle();
        chk("addr", 13'h0145, {4'h0, ram_addr});
        chk("wr", 13'h0001, {12'h000, ram_wr});
        chk("wdata", 13'h005A, {5'h00, ram_wdata});
        rf(7'h00);
        chk("wr", 13'h0000, {12'h000, ram_wr});
        idle();
        chk("rdata", 13'h005A, {5'h00, file_rdata});
        wf(7'h03, 8'h38);
        wf(7'h20, 8'h11);
        idle();
        chk("bank1", 13'h00A0, {4'h0, ram_addr});
        chk("stat", 13'h0038, {5'h00, status_out});
        wf(7'h03, 8'h18);
        wf(7'h20, 8'h22);
        idle();
        chk("bank0", 13'h0020, {4'h0, ram_addr});
        wf(7'h04, 8'h00);
        wf(7'h00, 8'hA5);
        idle();
        chk("wr", 13'h0000, {12'h000, ram_wr});
        rf(7'h00);
        idle();
        chk("self", 13'h0000, {5'h00, file_rdata});
    endtask

    // Computed jump across a page: software bumps the latch itself
    task automatic t_table();
        wf(7'h0A, 8'h02);
        wf(7'h02, 8'hFF);
        idle();
        chk("pc", 13'h02FF, program_counter);
        wf(7'h0A, 8'h03);
        wf(7'h02, 8'h00);
        idle();
        chk("pc", 13'h0300, program_counter);
    endtask

    // Reset in mid-run clears the counter again
    task automatic t_reset();
        wf(7'h02, 8'h77);
        rst_n <= 1'b0;
        idle();
        rst_n <= 1'b1;
        idle();
        chk("pc", 13'h0000, program_counter);
        chk("stat", 13'h0018, {5'h00, status_out});
    endtask

    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        conclude();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        op = PCS_OP_NONE;
        jump_field = 11'h000;
        file_addr = 7'h00;
        file_wr = 1'b0;
        file_rd = 1'b0;
        file_wdata = 8'h00;
        num_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        idle();
        chk("pc", 13'h0000, program_counter);
        t_flow();
        t_stack();
        t_data();
        t_table();
        t_reset();
        conclude();
    end
endmodule
